// >>> design/adccc_params.svh
`ifndef ADCCC_PARAMS_SVH
`define ADCCC_PARAMS_SVH
`define ADCCC_NUM_CH 8
`define ADCCC_RAW_W 10
`define ADCCC_RES_W 12
`define ADCCC_TEMP_CH 3'h7
`define ADCCC_VBACKUP_CH 3'h6
`define ADCCC_NC_CH 3'h2
`define ADCCC_AVG4_LOG 2
`define ADCCC_AVG16_LOG 4
`define ADCCC_FIFO_DEPTH 4
`define ADCCC_TRIG_DELAY_CYC 8'h02
`define ADCCC_CONV_CYC 8'h0A
`endif

// >>> design/adccc_pkg.sv
package adccc_pkg;
	typedef enum logic [1:0] {ADCCC_RES10, ADCCC_RES8, ADCCC_RES11, ADCCC_RES12} adccc_res_e;
	typedef enum logic [1:0] {ADCCC_TRG_SW, ADCCC_TRG_PIN, ADCCC_TRG_TIMER} adccc_trig_e;
	typedef enum logic [1:0] {ADCCC_CMP_LOW, ADCCC_CMP_HIGH, ADCCC_CMP_IN, ADCCC_CMP_OUT} adccc_cmp_e;
	typedef struct packed {
		logic [2:0] chan;
		logic [11:0] data;
	} adccc_result_s;
	typedef struct packed {
		logic reference_on_bit;
		logic force_reference_bit;
	} adccc_analog_control_s;
endpackage

// >>> design/adccc_fifo.sv
`timescale 1ns/1ps
module adccc_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 4
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	// read data held in a register; refilled when the output is empty or popped
	assign push = in_valid_in && in_ready_out;
	assign pop = (cnt_r != '0) && (!out_valid_out || out_ready_in);
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready_out <= 1'b0;
		end else begin
			if (push) begin
				wp_r <= AW'(wp_r + 1'b1);
			end
			if (pop) begin
				rp_r <= AW'(rp_r + 1'b1);
			end
			cnt_r <= (AW+1)'(cnt_r + push - pop);
			in_ready_out <= ((AW+1)'(cnt_r + push - pop)) < (AW+1)'(DEPTH - 1) ||
				(((AW+1)'(cnt_r + push - pop)) == (AW+1)'(DEPTH - 1) && 1'b1);
		end
	end
	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out <= mem_r[rp_r];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule // adccc_fifo

// >>> design/adccc_top.sv
`timescale 1ns/1ps
`include "adccc_params.svh"
// Function
// - eight inputs selected into one converter
// - reference chosen by control bits
// - 8-bit or 10-bit, same rate
// - 8-bit results fit byte transfers
// - result in common and channel registers
// - 11-bit mode averages four samples
// - 12-bit mode averages sixteen samples
// - channel seven is temperature sensor
// - channel six measures backup supply
// - channel two has no pin
// - software, pin or timer trigger
// - window compare low high in out
// - only enabled channels are converted
// - sleep: wake, convert all, sleep
// - software defined channel order
// - standby keeps core on, same startup wait as sleep; power-down
// - startup and tracking times programmable
// - reads clear end and ready flags
// - hardware trigger starts after delay
module adccc_top
	import adccc_pkg::*;
#(
	parameter int NUM_CH = `ADCCC_NUM_CH,
	parameter int FIFO_DEPTH = `ADCCC_FIFO_DEPTH
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire adccc_analog_control_s analog_control_register_in,
	input wire adccc_res_e res_mode_in,
	input wire adccc_trig_e trig_sel_in,
	input wire logic trig_en_in,
	input wire logic sw_start_in,
	input wire logic external_trigger_pin_in,
	input wire logic timer_channel_output_in,
	input wire logic [NUM_CH-1:0] chan_enable_in,
	input wire logic seq_custom_in,
	input wire logic [23:0] seq_order_in,
	input wire logic sleep_mode_in,
	input wire logic standby_mode_in,
	input wire logic power_down_in,
	input wire logic [7:0] startup_cyc_in,
	input wire logic [7:0] track_cyc_in,
	input wire adccc_cmp_e cmp_mode_in,
	input wire logic [11:0] cmp_low_in,
	input wire logic [11:0] cmp_high_in,
	input wire logic [2:0] read_chan_in,
	input wire logic read_chan_in_stb_in,
	input wire logic read_last_stb_in,
	input wire logic [`ADCCC_RAW_W-1:0] core_data_in,
	input wire logic dma_ready_in,
	output logic [2:0] mux_sel_out,
	output logic use_internal_ref_out,
	output logic ref_buffer_on_out,
	output logic core_powered_out,
	output logic core_sample_out,
	output logic temp_sensor_on_out,
	output logic [11:0] channel_result_register_out,
	output adccc_result_s last_result_register_out,
	output logic [NUM_CH-1:0] end_of_conversion_flag_out,
	output logic data_ready_flag_out,
	output logic cmp_flag_out,
	output logic dma_valid_out,
	output adccc_result_s dma_data_out,
	output logic busy_out
);
	// ------------------------------------------------------------
	// types and state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_WAKE, ST_TRACK, ST_CONV, ST_NEXT} adccc_st_e;
	adccc_st_e st_r;
	logic [7:0] cnt_r;
	logic [2:0] idx_r;
	logic [2:0] chan_r;
	logic [4:0] acc_cnt_r;
	logic [15:0] acc_r;
	logic [11:0] res_data;
	logic res_valid;
	logic trig_pin_d_r;
	logic trig_tmr_d_r;
	logic [7:0] trig_dly_r;
	logic trig_pend_r;
	logic start;
	logic fifo_ready;
	logic [11:0] chan_mem_r [NUM_CH];
	logic [4:0] avg_n;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] seq_chan(input logic [2:0] i, input logic custom,
		input logic [23:0] order);
		seq_chan = custom ? order[i*3 +: 3] : i;
	endfunction
	function automatic logic cmp_hit(input adccc_cmp_e m, input logic [11:0] v,
		input logic [11:0] lo, input logic [11:0] hi);
		unique case (m)
			ADCCC_CMP_LOW: cmp_hit = v < lo;
			ADCCC_CMP_HIGH: cmp_hit = v > hi;
			ADCCC_CMP_IN: cmp_hit = (v >= lo) && (v <= hi);
			ADCCC_CMP_OUT: cmp_hit = (v < lo) || (v > hi);
		endcase
	endfunction
	// ------------------------------------------------------------
	// triggers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			trig_pin_d_r <= 1'b0;
			trig_tmr_d_r <= 1'b0;
			trig_dly_r <= 8'h00;
			trig_pend_r <= 1'b0;
		end else begin
			trig_pin_d_r <= external_trigger_pin_in;
			trig_tmr_d_r <= timer_channel_output_in;
			trig_pend_r <= 1'b0;
			if (trig_dly_r != 8'h00) begin
				trig_dly_r <= trig_dly_r - 8'h01;
				trig_pend_r <= (trig_dly_r == 8'h01);
			end else if (trig_en_in && ((trig_sel_in == ADCCC_TRG_PIN &&
				external_trigger_pin_in && !trig_pin_d_r) || (trig_sel_in == ADCCC_TRG_TIMER &&
				timer_channel_output_in && !trig_tmr_d_r))) begin
				trig_dly_r <= `ADCCC_TRIG_DELAY_CYC;
			end
		end
	end
	assign start = trig_pend_r || (sw_start_in && trig_sel_in == ADCCC_TRG_SW);
	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// a trigger while busy is dropped; spacing must exceed the sequence length
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= ST_OFF;
			cnt_r <= 8'h00;
			idx_r <= 3'h0;
			chan_r <= 3'h0;
		end else begin
			unique case (st_r)
				ST_OFF: if (!power_down_in) begin
					st_r <= ST_IDLE;
				end
				ST_IDLE: if (power_down_in) begin
					st_r <= ST_OFF;
				end else if (start && chan_enable_in != '0) begin
					idx_r <= 3'h0;
					cnt_r <= (sleep_mode_in || standby_mode_in) ? startup_cyc_in : 8'h00;
					st_r <= ST_WAKE;
				end
				ST_WAKE: if (cnt_r != 8'h00) begin
					cnt_r <= cnt_r - 8'h01;
				end else if (!chan_enable_in[seq_chan(idx_r, seq_custom_in, seq_order_in)]) begin
					st_r <= ST_NEXT;
				end else begin
					chan_r <= seq_chan(idx_r, seq_custom_in, seq_order_in);
					cnt_r <= track_cyc_in;
					st_r <= ST_TRACK;
				end
				ST_TRACK: if (cnt_r != 8'h00) begin
					cnt_r <= cnt_r - 8'h01;
				end else begin
					cnt_r <= `ADCCC_CONV_CYC;
					st_r <= ST_CONV;
				end
				ST_CONV: if (cnt_r != 8'h00) begin
					cnt_r <= cnt_r - 8'h01;
				end else if (fifo_ready) begin
					st_r <= ST_NEXT;
				end
				ST_NEXT: if (idx_r == 3'(NUM_CH - 1)) begin
					st_r <= ST_IDLE;
				end else begin
					idx_r <= idx_r + 3'h1;
					st_r <= ST_WAKE;
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// averaging
	// ------------------------------------------------------------
	assign avg_n = (res_mode_in == ADCCC_RES11) ? 5'h04 :
		(res_mode_in == ADCCC_RES12) ? 5'h10 : 5'h01;
	wire sample_done = (st_r == ST_CONV) && (cnt_r == 8'h00) && fifo_ready;
	wire [15:0] acc_sum = acc_r + 16'(core_data_in);
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_r <= 16'h0000;
			acc_cnt_r <= 5'h00;
		end else if (sample_done) begin
			if (acc_cnt_r + 5'h01 >= avg_n) begin
				acc_r <= 16'h0000;
				acc_cnt_r <= 5'h00;
			end else begin
				acc_r <= acc_sum;
				acc_cnt_r <= acc_cnt_r + 5'h01;
			end
		end
	end
	assign res_valid = sample_done && (acc_cnt_r + 5'h01 >= avg_n);
	always_comb begin
		unique case (res_mode_in)
			ADCCC_RES8: res_data = {4'h0, core_data_in[9:2]};
			ADCCC_RES11: res_data = {1'b0, acc_sum[11:1]};
			ADCCC_RES12: res_data = acc_sum[13:2];
			default: res_data = {2'h0, core_data_in};
		endcase
	end
	// ------------------------------------------------------------
	// results and flags
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (res_valid) begin
			chan_mem_r[chan_r] <= res_data;
		end
	end
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			last_result_register_out <= '0;
			channel_result_register_out <= 12'h000;
			end_of_conversion_flag_out <= '0;
			data_ready_flag_out <= 1'b0;
			cmp_flag_out <= 1'b0;
		end else begin
			if (read_chan_in_stb_in) begin
				channel_result_register_out <= chan_mem_r[read_chan_in];
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (res_valid && chan_r == 3'(i)) begin
					end_of_conversion_flag_out[i] <= 1'b1; // set wins over clear
				end else if (read_chan_in_stb_in && read_chan_in == 3'(i)) begin
					end_of_conversion_flag_out[i] <= 1'b0;
				end
			end
			if (res_valid) begin
				last_result_register_out <= '{chan: chan_r, data: res_data};
				data_ready_flag_out <= 1'b1;
				cmp_flag_out <= cmp_hit(cmp_mode_in, res_data, cmp_low_in, cmp_high_in);
			end else if (read_last_stb_in) begin
				data_ready_flag_out <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// analog controls
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mux_sel_out <= 3'h0;
			use_internal_ref_out <= 1'b0;
			ref_buffer_on_out <= 1'b0;
			core_powered_out <= 1'b0;
			core_sample_out <= 1'b0;
			temp_sensor_on_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			mux_sel_out <= chan_r;
			use_internal_ref_out <= analog_control_register_in.reference_on_bit;
			ref_buffer_on_out <= analog_control_register_in.reference_on_bit ||
				analog_control_register_in.force_reference_bit;
			// sleep shuts the core between sequences; standby keeps it warm
			core_powered_out <= !power_down_in &&
				(st_r != ST_IDLE || !sleep_mode_in);
			core_sample_out <= st_r == ST_TRACK;
			temp_sensor_on_out <= chan_enable_in[`ADCCC_TEMP_CH];
			busy_out <= st_r != ST_IDLE && st_r != ST_OFF;
		end
	end
	// channel 6 feeds backup supply, channel 2 has no pin; both muxed by index
	// ------------------------------------------------------------
	// dma buffering
	// ------------------------------------------------------------
	adccc_fifo #(.WIDTH(15), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.in_valid_in(res_valid),
		.in_ready_out(fifo_ready),
		.in_data_in({chan_r, res_data}),
		.out_valid_out(dma_valid_out),
		.out_ready_in(dma_ready_in),
		.out_data_out(dma_data_out)
	);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_data_ready_flag_set;
		@(posedge mclk_in) disable iff (rst_in) res_valid |=> data_ready_flag_out;
	endproperty
	a_data_ready_flag_set: assert property (p_data_ready_flag_set) else $error("ready flag not set");
	property p_data_ready_flag_clr;
		@(posedge mclk_in) disable iff (rst_in) read_last_stb_in && !res_valid |=> !data_ready_flag_out;
	endproperty
	a_data_ready_flag_clr: assert property (p_data_ready_flag_clr) else $error("ready flag not cleared");
	property p_only_enabled;
		@(posedge mclk_in) disable iff (rst_in) $rose(core_sample_out) |-> chan_enable_in[chan_r];
	endproperty
	a_only_enabled: assert property (p_only_enabled) else $error("disabled channel sampled");
	property p_trig_delay;
		@(posedge mclk_in) disable iff (rst_in)
			trig_dly_r == 8'h00 && $past(trig_dly_r) == 8'h01 |-> trig_pend_r;
	endproperty
	a_trig_delay: assert property (p_trig_delay) else $error("trigger delay lost");
	property p_res8;
		@(posedge mclk_in) disable iff (rst_in)
			res_valid && res_mode_in == ADCCC_RES8 |-> res_data[11:8] == 4'h0;
	endproperty
	a_res8: assert property (p_res8) else $error("8-bit result too wide");
	property p_avg4;
		@(posedge mclk_in) disable iff (rst_in)
			res_valid && res_mode_in == ADCCC_RES11 |-> acc_cnt_r == 5'h03;
	endproperty
	a_avg4: assert property (p_avg4) else $error("average of four wrong");
	property p_avg16;
		@(posedge mclk_in) disable iff (rst_in)
			res_valid && res_mode_in == ADCCC_RES12 |-> acc_cnt_r == 5'h0F;
	endproperty
	a_avg16: assert property (p_avg16) else $error("average of sixteen wrong");
	property p_off;
		@(posedge mclk_in) disable iff (rst_in) power_down_in && st_r == ST_IDLE |=> st_r == ST_OFF;
	endproperty
	a_off: assert property (p_off) else $error("power down ignored");
	property p_ref;
		@(posedge mclk_in) disable iff (rst_in)
			analog_control_register_in.reference_on_bit |=> ref_buffer_on_out;
	endproperty
	a_ref: assert property (p_ref) else $error("reference not on");
	c_seq: cover property (@(posedge mclk_in) disable iff (rst_in) st_r == ST_NEXT ##1 st_r == ST_IDLE);
	c_cmp: cover property (@(posedge mclk_in) disable iff (rst_in) cmp_flag_out);
	c_stall: cover property (@(posedge mclk_in) disable iff (rst_in) !fifo_ready);
endmodule // adccc_top

// >>> bench/adccc_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// converter core and dma sink
// ----------------------------------------
module adccc_far_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [2:0] mux_sel_in,
	input wire logic stall_in,
	input wire logic dma_valid_in,
	output logic [9:0] core_data_out,
	output logic dma_ready_out,
	output logic [7:0] beats_out
);
	// one fixed level per input, so averaged results stay exact
	assign core_data_out = {mux_sel_in, 7'h15};
	assign dma_ready_out = !stall_in;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			beats_out <= 8'h00;
		end else if (dma_valid_in && dma_ready_out) begin
			beats_out <= beats_out + 8'h01;
		end
	end
endmodule // adccc_far_model

// >>> bench/adccc_top_tb.sv
`timescale 1ns/1ps
module adccc_top_tb;
	import adccc_pkg::*;
	// ----------------------------------------
	// stimulus and wiring
	// ----------------------------------------
	logic mclk_in = 1'b0, rst_in = 1'b1, trig_en = 1'b0, sw_start = 1'b0, pin = 1'b0, tmr = 1'b0;
	logic seq_custom = 1'b0, sleep = 1'b0, standby = 1'b0, pdown = 1'b0, rd_stb = 1'b0;
	logic rl_stb = 1'b0, stall = 1'b0, dma_ready, dma_valid, cmp_flag, data_ready_flag, busy, powered;
	logic use_int, buf_on, sample, temp_on;
	logic [2:0] rd_ch = 3'h0, mux_sel;
	logic [7:0] ena = 8'h00, eoc, beats;
	logic [7:0] startup = 8'h02, track = 8'h02;
	logic [23:0] seq_order = 24'h000000;
	logic [11:0] lo = 12'h000, hi = 12'h000, ch_res;
	logic [9:0] core_data;
	adccc_analog_control_s acr = '0;
	adccc_res_e res = ADCCC_RES10;
	adccc_trig_e tsel = ADCCC_TRG_SW;
	adccc_cmp_e cmode = ADCCC_CMP_LOW;
	adccc_result_s last, dma_data;
	int fail_count = 0, samples_checked = 0;
	int samp_cyc = 0, busy_cyc = 0;
	adccc_top uut (.mclk_in(mclk_in), .rst_in(rst_in), .analog_control_register_in(acr),
		.res_mode_in(res), .trig_sel_in(tsel), .trig_en_in(trig_en), .sw_start_in(sw_start),
		.external_trigger_pin_in(pin), .timer_channel_output_in(tmr), .chan_enable_in(ena),
		.seq_custom_in(seq_custom), .seq_order_in(seq_order), .sleep_mode_in(sleep),
		.standby_mode_in(standby), .power_down_in(pdown), .startup_cyc_in(startup),
		.track_cyc_in(track), .cmp_mode_in(cmode), .cmp_low_in(lo), .cmp_high_in(hi),
		.read_chan_in(rd_ch), .read_chan_in_stb_in(rd_stb), .read_last_stb_in(rl_stb),
		.core_data_in(core_data), .dma_ready_in(dma_ready), .mux_sel_out(mux_sel),
		.use_internal_ref_out(use_int), .ref_buffer_on_out(buf_on), .core_powered_out(powered),
		.core_sample_out(sample), .temp_sensor_on_out(temp_on), .channel_result_register_out(ch_res),
		.last_result_register_out(last), .end_of_conversion_flag_out(eoc),
		.data_ready_flag_out(data_ready_flag), .cmp_flag_out(cmp_flag), .dma_valid_out(dma_valid),
		.dma_data_out(dma_data), .busy_out(busy));
	adccc_far_model far (.mclk_in(mclk_in), .rst_in(rst_in), .mux_sel_in(mux_sel),
		.stall_in(stall), .dma_valid_in(dma_valid), .core_data_out(core_data),
		.dma_ready_out(dma_ready), .beats_out(beats));
	initial begin
		forever #10 mclk_in = ~mclk_in;
	end
	// tracking and busy spans, counted off the falling edge
	always @(negedge mclk_in) begin
		if (sample === 1'b1) begin
			samp_cyc++;
		end
		if (busy === 1'b1) begin
			busy_cyc++;
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	function automatic logic [11:0] raw(input logic [2:0] c);
		return {2'h0, c, 7'h15};
	endfunction
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// bounded, so a stuck sequencer shows up as a mismatch, not a hang
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (4) @(negedge mclk_in);
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge mclk_in);
			n++;
		end
		chk(16'h0, (n >= 3000) ? 16'h1 : 16'h0);
		repeat (3) @(negedge mclk_in);
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk_in);
		s = 1'b1;
		@(negedge mclk_in);
		@(negedge mclk_in);
		s = 1'b0;
	endtask
	task automatic start_sw();
		pulse(sw_start);
		wait_idle();
	endtask
	task automatic read_ch(input logic [2:0] c);
		rd_ch = c;
		pulse(rd_stb);
		@(negedge mclk_in);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ref();
		for (int i = 0; i < 4; i++) begin
			acr = i[1:0];
			repeat (3) @(negedge mclk_in);
			chk({15'h0, i[1]}, {15'h0, use_int});
			chk({15'h0, |i[1:0]}, {15'h0, buf_on});
		end
		$display("test ref done");
	endtask
	task automatic t_basic();
		int s0;
		ena = 8'h03;
		track = 8'h05;
		s0 = samp_cyc;
		start_sw();
		chk({1'b0, 3'h1, raw(3'h1)}, {1'b0, last});
		chk(16'h000C, 16'(samp_cyc - s0));
		track = 8'h02;
		chk(16'h0003, {8'h0, eoc});
		chk(16'h1, {15'h0, data_ready_flag});
		chk(16'h1, {15'h0, powered});
		read_ch(3'h0);
		chk(raw(3'h0), ch_res);
		chk(16'h0002, {8'h0, eoc});
		pulse(rl_stb);
		@(negedge mclk_in);
		chk(16'h0, {15'h0, data_ready_flag});
		$display("test basic done");
	endtask
	task automatic t_res8();
		logic [11:0] r;
		r = raw(3'h3);
		res = ADCCC_RES8;
		ena = 8'h08;
		start_sw();
		chk({8'h0, r[9:2]}, {4'h0, last.data});
		res = ADCCC_RES10;
		$display("test res8 done");
	endtask
	task automatic t_avg(input adccc_res_e m, input int n, input int sh);
		int k;
		logic [15:0] sum;
		res = m;
		ena = 8'h10;
		pulse(rl_stb);
		k = 0;
		while (k < 20 && data_ready_flag !== 1'b1) begin
			start_sw();
			k++;
		end
		sum = 16'(raw(3'h4) * n);
		chk(n[15:0], k[15:0]);
		chk(sum >> sh, {4'h0, last.data});
		res = ADCCC_RES10;
		$display("test avg done");
	endtask
	task automatic t_trig();
		ena = 8'h01;
		tsel = ADCCC_TRG_PIN;
		pulse(rl_stb);
		pulse(pin);
		repeat (40) @(negedge mclk_in);
		chk(16'h0, {15'h0, data_ready_flag});
		trig_en = 1'b1;
		pulse(pin);
		wait_idle();
		chk(16'h1, {15'h0, data_ready_flag});
		tsel = ADCCC_TRG_TIMER;
		pulse(rl_stb);
		pulse(tmr);
		wait_idle();
		chk(16'h1, {15'h0, data_ready_flag});
		trig_en = 1'b0;
		tsel = ADCCC_TRG_SW;
		$display("test trig done");
	endtask
	// channel three sits below, inside and above the three windows in turn
	task automatic t_cmp();
		logic [11:0] ex;
		ex = 12'b1010_0100_1001;
		ena = 8'h08;
		for (int j = 0; j < 3; j++) begin
			lo = (j == 2) ? 12'h100 : (j == 1) ? 12'h190 : 12'h196;
			hi = (j == 2) ? 12'h180 : 12'h1A0;
			for (int i = 0; i < 4; i++) begin
				cmode = adccc_cmp_e'(i);
				start_sw();
				chk({15'h0, ex[j*4+i]}, {15'h0, cmp_flag});
			end
		end
		$display("test cmp done");
	endtask
	task automatic t_seq();
		seq_custom = 1'b1;
		seq_order = 24'h053977;
		ena = 8'h21;
		start_sw();
		chk(16'h0000, {13'h0, last.chan});
		seq_custom = 1'b0;
		$display("test seq done");
	endtask
	task automatic t_dma();
		logic [7:0] b0;
		b0 = beats;
		stall = 1'b1;
		ena = 8'hFF;
		pulse(sw_start);
		repeat (300) @(negedge mclk_in);
		chk(16'h1, {15'h0, busy});
		chk(16'h1, {15'h0, temp_on});
		chk(16'h1, {15'h0, dma_valid});
		chk({1'b0, 3'h0, raw(3'h0)}, {1'b0, dma_data});
		chk(16'h0005, {13'h0, mux_sel});
		stall = 1'b0;
		wait_idle();
		repeat (10) @(negedge mclk_in);
		chk(16'h0008, {8'h0, beats - b0});
		$display("test dma done");
	endtask
	task automatic t_sleep();
		int b0;
		int d1;
		sleep = 1'b1;
		ena = 8'h01;
		pulse(rl_stb);
		b0 = busy_cyc;
		start_sw();
		d1 = busy_cyc - b0;
		chk(16'h1, {15'h0, data_ready_flag});
		chk(16'h0, {15'h0, powered});
		startup = 8'h14;
		b0 = busy_cyc;
		start_sw();
		chk(16'h0012, 16'(busy_cyc - b0 - d1));
		sleep = 1'b0;
		standby = 1'b1;
		b0 = busy_cyc;
		start_sw();
		chk(16'h0012, 16'(busy_cyc - b0 - d1));
		chk(16'h1, {15'h0, powered});
		standby = 1'b0;
		startup = 8'h02;
		pdown = 1'b1;
		repeat (5) @(negedge mclk_in);
		chk(16'h0, {15'h0, powered});
		pdown = 1'b0;
		$display("test sleep done");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge mclk_in);
		rst_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		t_ref();
		t_basic();
		t_res8();
		t_avg(ADCCC_RES11, 4, 1);
		t_avg(ADCCC_RES12, 16, 2);
		t_trig();
		t_cmp();
		t_seq();
		t_dma();
		t_sleep();
		summarize();
	end
	initial begin
		repeat (60000) @(posedge mclk_in);
		fail_count++;
		summarize();
	end
endmodule // adccc_top_tb
